// >>> inc/host_spi_pkg.sv
// Shared constants, types and register map of the host SPI slave block.
package host_spi_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses on the 15-bit host address space)
  // ----------------------------------------------------------------
  localparam logic [14:0] ADDR_WIDTH_SEL = 15'h1000;
  localparam logic [14:0] ADDR_PWM_FREQ_LO = 15'h1004;
  localparam logic [14:0] ADDR_PWM_FREQ_HI = 15'h1005;
  localparam logic [14:0] ADDR_PWM_DUTY = 15'h1008;
  localparam logic [14:0] ADDR_CMD_WR_LO = 15'h100c;
  localparam logic [14:0] ADDR_CMD_WR_HI = 15'h100d;
  localparam logic [14:0] ADDR_CMD_RD_LO = 15'h1010;
  localparam logic [14:0] ADDR_CMD_RD_HI = 15'h1011;
  // Header layout: bit 15 selects a write, bits 14:0 hold the address.
  localparam int HDR_WRITE_BIT = 7;
  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [1:0] WIDTH_RESET = 2'h0;
  localparam logic [13:0] PWM_FREQ_MIN = 14'h00fa;
  localparam logic [13:0] PWM_FREQ_MAX = 14'h2710;
  localparam logic [13:0] PWM_FREQ_RESET = 14'h00fa;
  localparam logic [7:0] PWM_DUTY_MAX = 8'h80;
  localparam logic [7:0] PWM_DUTY_RESET = 8'h00;
  localparam logic [25:0] MCLK_RATE_HZ = 26'h2625a00;
  localparam int PWM_STEP_BITS = 7;
  localparam int CMD_FIFO_BYTES = 4096;
  localparam int LINK_FIFO_DEPTH = 8;
  localparam logic [2:0] DUMMY_LAST = 3'h7;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WIDTH_SINGLE = 2'b00, WIDTH_DUAL = 2'b01, WIDTH_QUAD = 2'b10, WIDTH_RSVD = 2'b11
  } spi_width_t;
  typedef enum logic [1:0] {TAG_HDR_HI = 2'b00, TAG_HDR_LO = 2'b01, TAG_DATA = 2'b10} byte_tag_t;
  typedef enum logic [2:0] {
    PH_HDR_HI = 3'b000, PH_HDR_LO = 3'b001, PH_DUMMY = 3'b010, PH_READ = 3'b011, PH_WRITE = 3'b100
  } frame_phase_t;
  typedef struct packed {
    byte_tag_t tag;
    logic [7:0] data;
  } link_byte_t;
  typedef struct packed {
    logic gp1_or_quad_line3;
    logic gp0_or_quad_line2;
    logic miso_line1;
    logic mosi_line0;
  } spi_lines_t;
endpackage

// >>> core/host_spi_backlight_cmd_fifo.sv
// Host SPI slave with backlight PWM, command FIFO and link-crossing FIFO.
//
// Behaviour
// - After reset transfers are one bit wide: in on master-out, out on master-in.
// - Width field 01 selects dual lines, 10 quad lines, 11 is reserved.
// - Backlight enable is a PWM output set by a frequency and a duty register.
// - Frequency register accepts 250 Hz to 10 kHz and the output runs at it.
// - Duty accepts 0 to 128; 0 holds backlight off, 128 full on.
// - A 4 Kbyte command FIFO in memory, filled by host, consumed in order.
// - Read pointer advances only after the engine has executed a command.
// - Slave is selected by active-low chip select; ignored while it is high.
// - In quad mode general pins zero and one carry data lines two and three.
// - Pending events are signalled on an active-low interrupt output.
`timescale 1ns/1ps

module link_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // Write side
  input wire logic wclk,
  input wire logic wrst_n,
  input wire logic w_valid,
  input wire logic [WIDTH-1:0] w_data,
  output logic w_ready,
  // Read side
  input wire logic rclk,
  input wire logic rrst_n,
  output logic r_valid,
  output logic [WIDTH-1:0] r_data,
  input wire logic r_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wbin_reg, wgray_reg, rbin_reg, rgray_reg;
  logic [AW:0] rgray_s1_reg, rgray_s2_reg, wgray_s1_reg, wgray_s2_reg;
  logic [AW:0] wbin_next, rbin_next;

  // Gray pointers cross so that only one bit changes per step.
  assign wbin_next = wbin_reg + {{AW{1'b0}}, 1'b1};
  assign rbin_next = rbin_reg + {{AW{1'b0}}, 1'b1};
  assign w_ready = wgray_reg != {~rgray_s2_reg[AW:AW-1], rgray_s2_reg[AW-2:0]};
  assign r_valid = rgray_reg != wgray_s2_reg;
  assign r_data = mem_reg[rbin_reg[AW-1:0]];

  // Write pointer and storage.
  always_ff @(posedge wclk or negedge wrst_n) begin
    if (!wrst_n) begin
      wbin_reg <= '0;
      wgray_reg <= '0;
    end else if (w_valid && w_ready) begin
      wbin_reg <= wbin_next;
      wgray_reg <= wbin_next ^ (wbin_next >> 1);
    end
  end
  always_ff @(posedge wclk) begin
    if (w_valid && w_ready) begin
      mem_reg[wbin_reg[AW-1:0]] <= w_data;
    end
  end

  // Read pointer is synchronised into the write domain for the full test.
  always_ff @(posedge wclk or negedge wrst_n) begin
    if (!wrst_n) begin
      rgray_s1_reg <= '0;
      rgray_s2_reg <= '0;
    end else begin
      rgray_s1_reg <= rgray_reg;
      rgray_s2_reg <= rgray_s1_reg;
    end
  end

  // Read pointer.
  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      rbin_reg <= '0;
      rgray_reg <= '0;
    end else if (r_valid && r_ready) begin
      rbin_reg <= rbin_next;
      rgray_reg <= rbin_next ^ (rbin_next >> 1);
    end
  end

  // Write pointer is synchronised into the read domain for the empty test.
  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      wgray_s1_reg <= '0;
      wgray_s2_reg <= '0;
    end else begin
      wgray_s1_reg <= wgray_reg;
      wgray_s2_reg <= wgray_s1_reg;
    end
  end
endmodule

module host_spi_backlight_cmd_fifo import host_spi_pkg::*; #(
  parameter int CMD_BYTES = CMD_FIFO_BYTES
) (
  // System clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Host SPI link
  input wire logic sclk,
  input wire logic cs_n,
  input wire spi_lines_t io_in,
  output spi_lines_t io_out,
  output spi_lines_t io_oe,
  output logic int_n,
  // Graphics engine command port
  output logic [7:0] engine_cmd_byte,
  output logic engine_cmd_valid,
  input wire logic engine_cmd_done,
  // Event request and backlight
  input wire logic irq_request,
  output logic backlight_en
);
  localparam int PW = $clog2(CMD_BYTES);

  // ----------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------
  logic frame_rst;
  spi_width_t width_active_reg;
  frame_phase_t phase_reg;
  logic [2:0] bit_cnt_reg, dummy_cnt_reg, step;
  logic [3:0] cnt_sum;
  logic byte_done, link_push, link_ready;
  logic [7:0] rx_shift_reg, rx_next, tx_shift_reg, ret_byte_reg, rd_data_reg;
  logic tog_s1_reg, tog_s2_reg, tog_seen_reg, rd_tog_reg, hdr_write_reg;
  link_byte_t push_word;

  // Chip select high holds the frame logic in reset, so idle clocks are ignored.
  assign frame_rst = cs_n | ~rst_n;

  // Lines per clock follow the width latched between frames.
  always_comb begin
    unique case (width_active_reg)
      WIDTH_DUAL: step = 3'h2;
      WIDTH_QUAD: step = 3'h4;
      default: step = 3'h1;
    endcase
  end
  assign cnt_sum = {1'b0, bit_cnt_reg} + {1'b0, step};
  assign byte_done = cnt_sum[3] && (phase_reg != PH_DUMMY);

  // Incoming bits arrive most significant first; higher lines carry higher bits.
  always_comb begin
    unique case (width_active_reg)
      WIDTH_DUAL: rx_next = {rx_shift_reg[5:0], io_in.miso_line1, io_in.mosi_line0};
      WIDTH_QUAD: rx_next = {rx_shift_reg[3:0], io_in};
      default: rx_next = {rx_shift_reg[6:0], io_in.mosi_line0};
    endcase
  end

  // Frame sequencer: two header bytes, then write data or dummy plus read data.
  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      phase_reg <= PH_HDR_HI;
      bit_cnt_reg <= 3'h0;
      dummy_cnt_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
    end else begin
      rx_shift_reg <= rx_next;
      if (phase_reg != PH_DUMMY) begin
        bit_cnt_reg <= cnt_sum[2:0];
      end
      unique case (phase_reg)
        PH_HDR_HI: if (byte_done) phase_reg <= PH_HDR_LO;
        PH_HDR_LO: if (byte_done) phase_reg <= hdr_write_reg ? PH_WRITE : PH_DUMMY;
        PH_DUMMY: begin
          dummy_cnt_reg <= dummy_cnt_reg + 3'h1;
          if (dummy_cnt_reg == DUMMY_LAST) phase_reg <= PH_READ;
        end
        PH_READ, PH_WRITE: phase_reg <= phase_reg;
        default: phase_reg <= PH_HDR_HI;
      endcase
    end
  end

  // The write flag is the top bit of the first header byte.
  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      hdr_write_reg <= 1'b0;
    end else if (phase_reg == PH_HDR_HI && byte_done) begin
      hdr_write_reg <= rx_next[HDR_WRITE_BIT];
    end
  end

  // Bytes are pushed only while the crossing FIFO has room; a full FIFO drops.
  assign link_push = byte_done && (phase_reg != PH_READ) && link_ready;
  assign push_word = '{tag: (phase_reg == PH_HDR_HI) ? TAG_HDR_HI : (phase_reg == PH_HDR_LO) ? TAG_HDR_LO : TAG_DATA,
                       data: rx_next};

  // Read data crosses as a stable byte qualified by a synchronised toggle.
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_seen_reg <= 1'b0;
      ret_byte_reg <= 8'h00;
    end else begin
      tog_s1_reg <= rd_tog_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_seen_reg <= tog_s2_reg;
      if (tog_s2_reg != tog_seen_reg) ret_byte_reg <= rd_data_reg;
    end
  end

  // Outputs change on the falling edge so the host samples them on the rising one.
  always_ff @(negedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      tx_shift_reg <= 8'h00;
      io_out <= '0;
      io_oe <= '0;
    end else begin
      io_oe <= '0;
      io_oe.miso_line1 <= (width_active_reg == WIDTH_SINGLE) || (phase_reg == PH_READ);
      if (phase_reg == PH_READ && width_active_reg != WIDTH_SINGLE) begin
        io_oe.mosi_line0 <= 1'b1;
        io_oe.gp0_or_quad_line2 <= (width_active_reg == WIDTH_QUAD);
        io_oe.gp1_or_quad_line3 <= (width_active_reg == WIDTH_QUAD);
      end
      io_out <= '0;
      if (phase_reg == PH_READ) begin
        tx_shift_reg <= (bit_cnt_reg == 3'h0) ? (ret_byte_reg << step) : (tx_shift_reg << step);
        unique case (width_active_reg)
          WIDTH_DUAL: io_out[1:0] <= (bit_cnt_reg == 3'h0) ? ret_byte_reg[7:6] : tx_shift_reg[7:6];
          WIDTH_QUAD: io_out <= (bit_cnt_reg == 3'h0) ? ret_byte_reg[7:4] : tx_shift_reg[7:4];
          default: io_out.miso_line1 <= (bit_cnt_reg == 3'h0) ? ret_byte_reg[7] : tx_shift_reg[7];
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Crossing FIFO
  // ----------------------------------------------------------------
  link_byte_t pop_word;
  logic pop_valid, pop_ready, pop;
  link_fifo #(.WIDTH($bits(link_byte_t)), .DEPTH(LINK_FIFO_DEPTH)) u_link_fifo (
    .wclk(sclk), .wrst_n(rst_n), .w_valid(link_push), .w_data(push_word),
    .w_ready(link_ready), .rclk(mclk), .rrst_n(rst_n), .r_valid(pop_valid), .r_data(pop_word),
    .r_ready(pop_ready)
  );

  // ----------------------------------------------------------------
  // System clock domain: decode and registers
  // ----------------------------------------------------------------
  logic cs_s1_reg, cs_s2_reg, hdr_wr_m_reg, rd_pend_reg, wr_stb, advance;
  logic [14:0] addr_reg;
  spi_width_t spi_channel_width_select_reg;
  logic [13:0] backlight_pwm_frequency_reg;
  logic [7:0] pwm_duty_reg, rd_mux;
  logic [PW-1:0] cmd_wr_reg, cmd_rd_reg;
  logic [15:0] freq_next, wrp_next;
  logic [7:0] cmd_mem [CMD_BYTES];

  // Draining stalls for one cycle while a read answer is prepared.
  assign pop_ready = !rd_pend_reg;
  assign pop = pop_valid && pop_ready;
  assign wr_stb = pop && pop_word.tag == TAG_DATA;

  // Chip select synchroniser; the width only moves while no frame is open.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      width_active_reg <= WIDTH_SINGLE;
    end else begin
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      if (cs_s2_reg) width_active_reg <= spi_channel_width_select_reg;
    end
  end

  // Header decode, address auto-increment on data and read answers.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= 15'h0000;
      hdr_wr_m_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_tog_reg <= 1'b0;
      rd_data_reg <= 8'h00;
    end else begin
      rd_pend_reg <= 1'b0;
      if (rd_pend_reg) begin
        rd_data_reg <= rd_mux;
        rd_tog_reg <= ~rd_tog_reg;
      end
      if (pop) begin
        unique case (pop_word.tag)
          TAG_HDR_HI: begin
            addr_reg[14:8] <= pop_word.data[6:0];
            hdr_wr_m_reg <= pop_word.data[HDR_WRITE_BIT];
          end
          TAG_HDR_LO: begin
            addr_reg[7:0] <= pop_word.data;
            rd_pend_reg <= !hdr_wr_m_reg;
          end
          default: addr_reg <= addr_reg + 15'h0001;
        endcase
      end
    end
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    rd_mux = 8'h00;
    if (addr_reg < 15'(CMD_BYTES)) rd_mux = cmd_mem[addr_reg[PW-1:0]];
    else if (addr_reg == ADDR_WIDTH_SEL) rd_mux = {6'h00, spi_channel_width_select_reg};
    else if (addr_reg == ADDR_PWM_FREQ_LO) rd_mux = backlight_pwm_frequency_reg[7:0];
    else if (addr_reg == ADDR_PWM_FREQ_HI) rd_mux = {2'h0, backlight_pwm_frequency_reg[13:8]};
    else if (addr_reg == ADDR_PWM_DUTY) rd_mux = pwm_duty_reg;
    else if (addr_reg == ADDR_CMD_WR_LO) rd_mux = 8'(16'(cmd_wr_reg));
    else if (addr_reg == ADDR_CMD_WR_HI) rd_mux = 8'(16'(cmd_wr_reg) >> 8);
    else if (addr_reg == ADDR_CMD_RD_LO) rd_mux = 8'(16'(cmd_rd_reg));
    else if (addr_reg == ADDR_CMD_RD_HI) rd_mux = 8'(16'(cmd_rd_reg) >> 8);
  end

  // Width select; the reserved code is refused and the old width kept.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) spi_channel_width_select_reg <= spi_width_t'(WIDTH_RESET);
    else if (wr_stb && addr_reg == ADDR_WIDTH_SEL && pop_word.data[1:0] != WIDTH_RSVD) begin
      spi_channel_width_select_reg <= spi_width_t'(pop_word.data[1:0]);
    end
  end

  // Backlight registers; out-of-range values are clamped rather than stored raw.
  assign freq_next = (addr_reg == ADDR_PWM_FREQ_LO) ? {2'h0, backlight_pwm_frequency_reg[13:8], pop_word.data} :
                     {pop_word.data, backlight_pwm_frequency_reg[7:0]};
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      backlight_pwm_frequency_reg <= PWM_FREQ_RESET;
      pwm_duty_reg <= PWM_DUTY_RESET;
    end else if (wr_stb) begin
      if (addr_reg == ADDR_PWM_FREQ_LO || addr_reg == ADDR_PWM_FREQ_HI) begin
        if (freq_next < 16'(PWM_FREQ_MIN)) backlight_pwm_frequency_reg <= PWM_FREQ_MIN;
        else if (freq_next > 16'(PWM_FREQ_MAX)) backlight_pwm_frequency_reg <= PWM_FREQ_MAX;
        else backlight_pwm_frequency_reg <= freq_next[13:0];
      end
      if (addr_reg == ADDR_PWM_DUTY) begin
        pwm_duty_reg <= (pop_word.data > PWM_DUTY_MAX) ? PWM_DUTY_MAX : pop_word.data;
      end
    end
  end

  // Command memory is written by the host through the same byte stream.
  always_ff @(posedge mclk) begin
    if (wr_stb && addr_reg < 15'(CMD_BYTES)) cmd_mem[addr_reg[PW-1:0]] <= pop_word.data;
  end

  // Command pointers: host owns the write pointer, the engine the read pointer.
  assign wrp_next = (addr_reg == ADDR_CMD_WR_LO) ? {8'(16'(cmd_wr_reg) >> 8), pop_word.data} :
                    {pop_word.data, 8'(16'(cmd_wr_reg))};
  assign advance = engine_cmd_done && engine_cmd_valid;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_wr_reg <= '0;
      cmd_rd_reg <= '0;
      engine_cmd_byte <= 8'h00;
      engine_cmd_valid <= 1'b0;
    end else begin
      if (wr_stb && (addr_reg == ADDR_CMD_WR_LO || addr_reg == ADDR_CMD_WR_HI)) begin
        cmd_wr_reg <= wrp_next[PW-1:0];
      end
      if (advance) cmd_rd_reg <= cmd_rd_reg + PW'(1);
      engine_cmd_byte <= cmd_mem[cmd_rd_reg];
      engine_cmd_valid <= (cmd_rd_reg != cmd_wr_reg) && !advance;
    end
  end

  // Interrupt is active low and follows the event request one cycle later.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) int_n <= 1'b1;
    else int_n <= ~irq_request;
  end

  // ----------------------------------------------------------------
  // Backlight PWM
  // ----------------------------------------------------------------
  // A phase accumulator avoids a divider: it ticks 128 times per PWM period.
  logic [25:0] acc_reg, acc_sum;
  logic [PWM_STEP_BITS-1:0] step_cnt_reg;
  assign acc_sum = acc_reg + {5'h00, backlight_pwm_frequency_reg, 7'h00};
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= 26'h0000000;
      step_cnt_reg <= '0;
      backlight_en <= 1'b0;
    end else begin
      if (acc_sum >= MCLK_RATE_HZ) begin
        acc_reg <= acc_sum - MCLK_RATE_HZ;
        step_cnt_reg <= step_cnt_reg + PWM_STEP_BITS'(1);
      end else begin
        acc_reg <= acc_sum;
      end
      backlight_en <= {1'b0, step_cnt_reg} < pwm_duty_reg;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  pwm_off_a: assert property (@(posedge mclk) disable iff (!rst_n) pwm_duty_reg == 8'h00 |=> !backlight_en)
    else $error("backlight on with zero duty");
  pwm_full_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pwm_duty_reg == PWM_DUTY_MAX |=> backlight_en)
    else $error("backlight off with full duty");
  freq_range_a: assert property (@(posedge mclk) disable iff (!rst_n)
    backlight_pwm_frequency_reg >= PWM_FREQ_MIN && backlight_pwm_frequency_reg <= PWM_FREQ_MAX)
    else $error("backlight frequency outside range");
  width_legal_a: assert property (@(posedge mclk) disable iff (!rst_n)
    spi_channel_width_select_reg != WIDTH_RSVD)
    else $error("reserved width stored");
  width_frame_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !cs_s2_reg && $past(!cs_s2_reg) |-> $stable(width_active_reg))
    else $error("width changed inside a frame");
  rdptr_cause_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cmd_rd_reg != $past(cmd_rd_reg) |-> $past(engine_cmd_done) && $past(engine_cmd_valid))
    else $error("read pointer moved without execution");
  rdptr_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    engine_cmd_done && engine_cmd_valid |=> cmd_rd_reg == $past(cmd_rd_reg) + PW'(1) && !engine_cmd_valid)
    else $error("read pointer did not step by one");
  irq_out_a: assert property (@(posedge mclk) disable iff (!rst_n) irq_request |=> !int_n)
    else $error("interrupt not asserted");
  quad_lines_a: assert property (@(negedge sclk) disable iff (frame_rst)
    io_oe.gp0_or_quad_line2 |-> width_active_reg == WIDTH_QUAD && phase_reg == PH_READ)
    else $error("line two driven outside quad read");
  single_miso_a: assert property (@(posedge sclk) disable iff (frame_rst)
    width_active_reg == WIDTH_SINGLE |-> !io_oe.mosi_line0)
    else $error("master-out line driven in single mode");
endmodule

// >>> dv/spi_host_model.sv
// Behavioural SPI host that frames register and command traffic into the slave.
`timescale 1ns/1ps
module spi_host_model import host_spi_pkg::*; (
  // Link pins toward the slave
  output logic sclk,
  output logic cs_n,
  output spi_lines_t host_drv,
  // Pins driven by the slave
  input wire spi_lines_t io_out,
  input wire spi_lines_t io_oe
);
  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  int nb = 1;
  spi_lines_t oe_seen;
  // The clock idles low and stands still between frames.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    host_drv = 4'h5;
    oe_seen = 4'h0;
  end
  // Data changes while the clock is low; the slave answer is taken just before each rise.
  task automatic shift_byte(input logic [7:0] b, output logic [7:0] r);
    logic [7:0] sh;
    sh = b;
    r = 8'h00;
    for (int k = 0; k < 8 / nb; k++) begin
      if (nb == 1) host_drv.mosi_line0 = sh[7];
      else if (nb == 2) host_drv[1:0] = sh[7:6];
      else host_drv = sh[7:4];
      sh = sh << nb;
      #62.5;
      r = (r << nb) | (nb == 1 ? {7'h0, io_out[1]} : nb == 2 ? {6'h0, io_out[1:0]} : {4'h0, io_out});
      oe_seen = oe_seen | io_oe;
      sclk = 1'b1;
      #62.5;
      sclk = 1'b0;
    end
  endtask
  // With sel low the clock still runs but the slave is never selected.
  task automatic frame(input logic sel, input logic w, input logic [14:0] a, input logic [7:0] d,
                       output logic [7:0] q);
    logic [7:0] junk;
    cs_n = ~sel;
    #100;
    shift_byte({w, a[14:8]}, junk);
    shift_byte(a[7:0], junk);
    if (w) shift_byte(d, junk);
    else begin
      repeat (8) begin
        #62.5;
        sclk = 1'b1;
        #62.5;
        sclk = 1'b0;
      end
      shift_byte(8'h00, q);
    end
    #62.5;
    cs_n = 1'b1;
    host_drv = ~host_drv; // Released lines must not keep their last value.
    #400;
  endtask
endmodule

// >>> dv/host_spi_backlight_cmd_fifo_tb_top.sv
// Self-checking testbench of the host SPI slave with backlight PWM and command FIFO.
`timescale 1ns/1ps
module host_spi_backlight_cmd_fifo_tb_top import host_spi_pkg::*;;
  // ----------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------
  logic mclk = 1'b0, rst_n = 1'b0, sclk, cs_n, int_n, engine_cmd_valid, backlight_en;
  logic engine_cmd_done = 1'b0, irq_request = 1'b0;
  logic [7:0] engine_cmd_byte, q;
  logic [7:0] cb [8];
  spi_lines_t io_in, io_out, io_oe, host_drv;
  int errors = 0, n_checks = 0, hi, r, d, n;
  // Each line carries whoever enables it; the host fills the rest.
  assign io_in = (io_oe & io_out) | (~io_oe & host_drv);
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  host_spi_backlight_cmd_fifo #(.CMD_BYTES(64)) host_spi_backlight_cmd_fifo_inst (.mclk(mclk), .rst_n(rst_n),
    .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .int_n(int_n),
    .engine_cmd_byte(engine_cmd_byte), .engine_cmd_valid(engine_cmd_valid),
    .engine_cmd_done(engine_cmd_done), .irq_request(irq_request), .backlight_en(backlight_en));
  spi_host_model host_inst (.sclk(sclk), .cs_n(cs_n), .host_drv(host_drv), .io_out(io_out), .io_oe(io_oe));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] v);
    logic [7:0] junk;
    host_inst.frame(1'b1, 1'b1, a, v, junk);
  endtask
  task automatic rd(input logic [14:0] a, output logic [7:0] v);
    host_inst.frame(1'b1, 1'b0, a, 8'h00, v);
  endtask
  // Counts high cycles and rising edges over a window of five nominal periods.
  task automatic pwm(input logic [7:0] v);
    logic last;
    wr(ADDR_PWM_DUTY, v);
    repeat (4000) @(posedge mclk);
    hi = 0;
    r = 0;
    last = backlight_en;
    repeat (20000) begin
      @(posedge mclk);
      hi += int'(backlight_en === 1'b1);
      r += int'(backlight_en === 1'b1 && last === 1'b0);
      last = backlight_en;
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // The watchdog cuts a hung handshake short; a clean run needs about 2 ms, mostly PWM windows.
  initial begin
    #2400us;
    errors++;
    final_report();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(12914));
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("idle backlight", 0, backlight_en);
    rd(ADDR_WIDTH_SEL, q);
    chk("width reset", 0, q);
    rd(ADDR_PWM_FREQ_LO, q);
    chk("freq reset", 16'h00fa, q);
    // Every width code; the new width starts with the following frame.
    for (int c = 1; c < 4; c++) begin
      wr(ADDR_WIDTH_SEL, 8'(c));
      if (c != 3) host_inst.nb = (c == 1) ? 2 : 4;
      d = $urandom % 129;
      wr(ADDR_PWM_DUTY, 8'(d));
      host_inst.oe_seen = 4'h0;
      rd(ADDR_PWM_DUTY, q);
      chk("duty readback", 16'(d), q);
    end
    chk("quad enables", 16'h000f, host_inst.oe_seen);
    wr(ADDR_WIDTH_SEL, 8'h00);
    host_inst.nb = 1;
    wr(ADDR_PWM_DUTY, 8'hc8);
    rd(ADDR_PWM_DUTY, q);
    chk("duty clamp", 16'h0080, q);
    host_inst.frame(1'b0, 1'b1, ADDR_PWM_DUTY, 8'h11, q);
    rd(ADDR_PWM_DUTY, q);
    chk("deselected write", 16'h0080, q);
    // Commands land in memory before the write pointer announces them.
    n = 5 + $urandom % 4;
    for (int i = 0; i < n; i++) begin
      cb[i] = 8'($urandom);
      wr(15'(i), cb[i]);
    end
    wr(ADDR_CMD_WR_LO, 8'(n));
    rd(ADDR_CMD_RD_LO, q);
    chk("rd ptr before run", 0, q);
    for (int i = 0; i < n; i++) begin
      chk("cmd valid", 1, engine_cmd_valid);
      chk("cmd byte", cb[i], engine_cmd_byte);
      @(posedge mclk);
      engine_cmd_done <= 1'b1;
      @(posedge mclk);
      engine_cmd_done <= 1'b0;
      repeat (3) @(posedge mclk);
    end
    chk("cmd drained", 0, engine_cmd_valid);
    wr(ADDR_CMD_RD_LO, 8'h33);
    rd(ADDR_CMD_RD_LO, q);
    chk("rd ptr after run", 16'(n), q);
    @(posedge mclk);
    irq_request <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("irq low", 0, int_n);
    irq_request <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("irq high", 1, int_n);
    wr(ADDR_PWM_FREQ_LO, 8'h10);
    wr(ADDR_PWM_FREQ_HI, 8'h27);
    pwm(8'h00);
    chk("duty zero", 0, 16'(hi));
    pwm(8'h80);
    chk("duty full", 16'(20000), 16'(hi));
    d = 16 + $urandom % 97;
    pwm(8'(d));
    chk("pwm rate", 1, 16'(r >= 5 && r <= 6));
    chk("pwm share", 1, 16'(hi * 128 >= d * 20000 - 512000 && hi * 128 <= d * 20000 + 512000));
    final_report();
  end
endmodule
